// ===== design/qpcf_top.sv
// Serial control, parallel OR and shorted-load fault logic of a four-channel predriver
//
// Summary of operation
// R1 - After select falls, each rising serial clock shifts data input into LSB.
// R2 - Controller drops select before the first falling serial clock edge.
// R3 - Controller gives at least four clocks while select is low.
// R4 - Under four clocks, leftover fault bits become control bits at select rise.
// R5 - Eight bits may pass; first four out are faults, last four in control.
// R6 - Select rise copies the shift register into the control register.
// R7 - Control bit 0 turns its gate off, 1 turns it on.
// R8 - Serial output changes on falling serial clock edges.
// R9 - Fault MSB shows after select falls; three more follow on later clocks.
// R10 - Faults load only at select fall; absent faults then go unreported.
// R11 - Select rise stops input, floats output, latches control, clears shift register.
// R12 - Controller raises select only after the last data bit is clocked.
// R13 - Gate is on when parallel input or serial control bit asks on.
// R14 - Parallel inputs act at once, needing no serial activity.
// R15 - Parallel input low then high clears a short disable and re-enables.
// R16 - Gate turning on starts a 60 us mask ignoring the drain.
// R17 - After mask, drain high for deglitch time sets flag, gate off.
// R18 - Shorted load makes the gate a low-duty pulse train until fixed or off.
// R19 - Shorted load retries automatically; fault clears once the short goes.
// R20 - Fault bits 0-3 map one per channel.
// R21 - Short deglitch time is 12 us.
// R22 - Retry pulses repeat every 10 ms.
// R23 - Each retry pulse lasts 68 us.
// R24 - Fault flag resets at select fall if no fault remains.
// R25 - Bits shifted past four leave on serial output for cascading.
`timescale 1ns/1ps
`default_nettype none

module qpcf_top
    import qpcf_pkg::*;
#(
    parameter int unsigned RETRY_PERIOD_CYCLES = RETRY_PERIOD_CYC
) (
    input wire logic clk,                      // 20 MHz system clock
    input wire logic rst,                      // Asynchronous reset, active high
    input wire logic sclk,                     // Serial clock pin
    input wire logic csN,                      // Chip select pin, active low
    input wire logic sdi,                      // Serial data input pin
    input wire logic [3:0] parallelCtrlIn,     // Parallel on requests
    input wire logic [3:0] drainSenseIn,       // Drain above fault reference
    output logic sdo,                          // Serial data output value
    output logic sdoOe,                        // Serial output enable
    output logic [3:0] gateDriveOut,           // Gate drive per channel
    output logic faultFlagN                    // Fault flag, active low
);

    // ========================================================
    // Derived counter limits
    // ========================================================
    localparam logic [CNT_W-1:0] MASK_LAST = CNT_W'(TURN_ON_MASK_CYC - 1);
    localparam logic [CNT_W-1:0] DG_LAST = CNT_W'(SHORT_DEGLITCH_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RETRY_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_LAST =
        CNT_W'(RETRY_PERIOD_CYCLES - RETRY_PULSE_CYC - 1);

    // ========================================================
    // State
    // ========================================================
    typedef struct packed {
        logic [2:0] sclkSy;              // [0] first, [1] second, [2] previous
        logic [2:0] csSy;
        logic [1:0] sdiSy;
        logic [3:0] par1;
        logic [3:0] par2;
        logic [3:0] parPrev;
        logic [3:0] drain1;
        logic [3:0] drain2;
        logic [3:0] shift;
        logic [3:0] ctrl;
        logic sdo;
        logic sdoOe;
        logic faultFlagN;
        logic [3:0] gate;
        logic [3:0] fault;
        qpcf_ch_state_t [3:0] st;
        logic [3:0][CNT_W-1:0] cnt;
    } qpcf_state_t;

    qpcf_state_t q;
    qpcf_state_t next_q;

    logic sclkRise;
    logic sclkFall;
    logic csFall;
    logic csRise;
    logic csLow;
    logic [3:0] req;
    logic [3:0] parRise;
    logic [3:0] newFault;

    // Edge detection on synchronised pins
    assign sclkRise = q.sclkSy[1] & ~q.sclkSy[2];
    assign sclkFall = ~q.sclkSy[1] & q.sclkSy[2];
    assign csFall = ~q.csSy[1] & q.csSy[2];
    assign csRise = q.csSy[1] & ~q.csSy[2];
    assign csLow = ~q.csSy[1] & ~q.csSy[2];
    // Either interface turns a channel on, parallel without any framing
    assign req = q.ctrl | q.par2;                       // R13 R14 R7
    assign parRise = q.par2 & ~q.parPrev;

    // ========================================================
    // Next-state logic
    // ========================================================
    always_comb begin
        next_q = q;
        // Two-flop synchronisers, plus a third stage for edges
        next_q.sclkSy = {q.sclkSy[1], q.sclkSy[0], sclk};
        next_q.csSy = {q.csSy[1], q.csSy[0], csN};
        next_q.sdiSy = {q.sdiSy[0], sdi};
        next_q.par1 = parallelCtrlIn;
        next_q.par2 = q.par1;
        next_q.parPrev = q.par2;
        next_q.drain1 = drainSenseIn;
        next_q.drain2 = q.drain1;

        // Serial frame handling
        if (csFall) begin
            next_q.shift = q.fault;                     // R10 R20
            next_q.sdo = q.fault[3];                    // R9
            next_q.sdoOe = 1'b1;
        end else if (csRise) begin
            next_q.ctrl = q.shift;                      // R6 R4 R5
            next_q.shift = SHIFT_RST;                   // R11
            next_q.sdoOe = 1'b0;                        // R11
        end else if (csLow) begin
            if (sclkRise) begin
                next_q.shift = {q.shift[2:0], q.sdiSy[1]};   // R1
            end
            if (sclkFall) begin
                next_q.sdo = q.shift[3];                // R8 R25
            end
        end

        // Per-channel gate and shorted-load supervision
        for (int i = 0; i < NUM_CH; i++) begin
            case (q.st[i])
                CH_OFF: begin
                    next_q.cnt[i] = '0;
                    if (req[i]) begin
                        next_q.st[i] = CH_MASK;         // R16
                    end
                end
                CH_MASK: begin
                    next_q.cnt[i] = q.cnt[i] + 1'b1;
                    if (!req[i]) begin
                        next_q.st[i] = CH_OFF;
                    end else if (q.cnt[i] == MASK_LAST) begin
                        next_q.st[i] = CH_ON;           // R16
                        next_q.cnt[i] = '0;
                    end
                end
                CH_ON: begin
                    next_q.cnt[i] = '0;
                    if (!req[i]) begin
                        next_q.st[i] = CH_OFF;
                    end else if (q.drain2[i]) begin
                        next_q.st[i] = CH_GLITCH;
                    end
                end
                CH_GLITCH: begin
                    next_q.cnt[i] = q.cnt[i] + 1'b1;
                    if (!req[i]) begin
                        next_q.st[i] = CH_OFF;
                    end else if (!q.drain2[i]) begin
                        next_q.st[i] = CH_ON;
                        next_q.cnt[i] = '0;
                    end else if (q.cnt[i] == DG_LAST) begin
                        next_q.st[i] = CH_WAIT;         // R17 R21
                        next_q.fault[i] = 1'b1;         // R17
                        next_q.cnt[i] = '0;
                    end
                end
                CH_WAIT: begin
                    next_q.cnt[i] = q.cnt[i] + 1'b1;
                    if (!req[i]) begin
                        next_q.st[i] = CH_OFF;          // R18
                        next_q.fault[i] = 1'b0;
                    end else if (parRise[i]) begin
                        next_q.st[i] = CH_MASK;         // R15
                        next_q.fault[i] = 1'b0;
                        next_q.cnt[i] = '0;
                    end else if (q.cnt[i] == WAIT_LAST) begin
                        next_q.st[i] = CH_PULSE;        // R18 R22
                        next_q.cnt[i] = '0;
                    end
                end
                CH_PULSE: begin
                    next_q.cnt[i] = q.cnt[i] + 1'b1;
                    if (!req[i]) begin
                        next_q.st[i] = CH_OFF;
                        next_q.fault[i] = 1'b0;
                    end else if (q.cnt[i] == PULSE_LAST) begin
                        next_q.cnt[i] = '0;
                        if (q.drain2[i]) begin
                            next_q.st[i] = CH_WAIT;     // R19 R23
                        end else begin
                            next_q.st[i] = CH_ON;       // R19
                            next_q.fault[i] = 1'b0;
                        end
                    end
                end
                default: begin
                    next_q.st[i] = CH_OFF;
                    next_q.cnt[i] = '0;
                end
            endcase
            // Gate is off only when idle or waiting between retries
            next_q.gate[i] = (next_q.st[i] != CH_OFF) && (next_q.st[i] != CH_WAIT);   // R7
        end

        // Fault bits that set on this edge
        newFault = next_q.fault & ~q.fault;
        // Fault flag: a new fault wins over the refresh at select fall
        if (|newFault) begin
            next_q.faultFlagN = 1'b0;                   // R17
        end else if (csFall) begin
            next_q.faultFlagN = ~(|q.fault);            // R24
        end
    end

    // ========================================================
    // State register
    // ========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.sclkSy <= SYNC3_LOW_RST;
            q.csSy <= SYNC3_RST;
            q.sdiSy <= 2'h0;
            q.par1 <= 4'h0;
            q.par2 <= 4'h0;
            q.parPrev <= 4'h0;
            q.drain1 <= 4'h0;
            q.drain2 <= 4'h0;
            q.shift <= SHIFT_RST;
            q.ctrl <= CTRL_RST;
            q.sdo <= SDO_RST;
            q.sdoOe <= SDO_OE_RST;
            q.faultFlagN <= FLAG_N_RST;
            q.gate <= GATE_RST;
            q.fault <= FAULT_RST;
            q.st <= {NUM_CH{CH_OFF}};
            q.cnt <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign sdo = q.sdo;
    assign sdoOe = q.sdoOe;
    assign gateDriveOut = q.gate;
    assign faultFlagN = q.faultFlagN;

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_retryStart;
        q.st[0] == CH_WAIT ##1 q.st[0] == CH_PULSE;
    endsequence

    sequence s_shortFound;
        q.st[0] == CH_GLITCH && q.cnt[0] == DG_LAST && q.drain2[0] && req[0];
    endsequence

    a_shift_in: assert property (csLow && sclkRise
        |=> q.shift == {$past(q.shift[2:0]), $past(q.sdiSy[1])}) // R1
        else $error("serial data not shifted into LSB");
    a_ctrl_latch: assert property (csRise |=> q.ctrl == $past(q.shift)) // R6
        else $error("control register not loaded at select rise");
    a_sdo_float: assert property (csRise |=> !sdoOe && q.shift == 4'h0) // R11
        else $error("select rise did not float output and clear register");
    a_fault_load: assert property (csFall
        |=> q.shift == $past(q.fault) && sdo == $past(q.fault[3]) && sdoOe) // R10
        else $error("fault bits not loaded at select fall");
    a_sdo_fall: assert property (csLow && sclkFall |=> sdo == $past(q.shift[3])) // R8
        else $error("serial output not updated on falling clock");
    a_gate_on: assert property (q.st[0] == CH_OFF && req[0]
        |=> gateDriveOut[0] && q.st[0] == CH_MASK) // R13
        else $error("request did not turn gate on");
    a_mask_hold: assert property (q.st[0] == CH_MASK && q.cnt[0] < MASK_LAST && req[0]
        |=> q.st[0] == CH_MASK && !q.fault[0]) // R16
        else $error("mask interval left early");
    a_short_trip: assert property (s_shortFound
        |=> q.fault[0] && !gateDriveOut[0] && !faultFlagN) // R17
        else $error("shorted load not flagged and shut off");
    a_retry_pulse: assert property (s_retryStart |-> gateDriveOut[0] && q.cnt[0] == 0) // R23
        else $error("retry pulse not driven on gate");
    a_par_clear: assert property (q.st[2] == CH_WAIT && parRise[2] && req[2]
        |=> q.st[2] == CH_MASK && !q.fault[2]) // R15
        else $error("parallel toggle did not re-enable channel");
    a_flag_clear: assert property (csFall && q.fault == 4'h0 && newFault == 4'h0
        |=> faultFlagN) // R24
        else $error("fault flag not reset at select fall");

endmodule : qpcf_top

`default_nettype wire

// ===== design/qpcf_pkg.sv
// Constants and types for the quad predriver control and fault block
package qpcf_pkg;

    // ========================================================
    // Clock and timing
    // ========================================================
    localparam int unsigned CLK_PERIOD_NS = 50;              // 20 MHz system clock
    localparam int unsigned TURN_ON_MASK_TIME_NS = 60000;    // 60 us
    localparam int unsigned SHORT_DEGLITCH_TIME_NS = 12000;  // 12 us
    localparam int unsigned RETRY_PERIOD_NS = 10000000;      // 10 ms
    localparam int unsigned RETRY_PULSE_WIDTH_NS = 68000;    // 68 us

    // Least times round up to whole cycles
    localparam int unsigned TURN_ON_MASK_CYC =
        (TURN_ON_MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHORT_DEGLITCH_CYC =
        (SHORT_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RETRY_PERIOD_CYC = RETRY_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned RETRY_PULSE_CYC = RETRY_PULSE_WIDTH_NS / CLK_PERIOD_NS;

    // ========================================================
    // Widths and reset values
    // ========================================================
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CNT_W = 18;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] SHIFT_RST = 4'h0;
    localparam logic [3:0] FAULT_RST = 4'h0;
    localparam logic [3:0] GATE_RST = 4'h0;
    localparam logic SDO_RST = 1'h0;
    localparam logic SDO_OE_RST = 1'h0;
    localparam logic FLAG_N_RST = 1'h1;
    localparam logic [2:0] SYNC3_RST = 3'h7;
    localparam logic [2:0] SYNC3_LOW_RST = 3'h0;

    // ========================================================
    // Channel state machine
    // ========================================================
    typedef enum logic [5:0] {
        CH_OFF = 6'h01,      // Gate off, no request
        CH_MASK = 6'h02,     // Gate on, drain comparison ignored
        CH_ON = 6'h04,       // Gate on, drain watched
        CH_GLITCH = 6'h08,   // Gate on, drain high, deglitching
        CH_WAIT = 6'h10,     // Shorted load, gate off between retries
        CH_PULSE = 6'h20     // Shorted load, retry pulse on the gate
    } qpcf_ch_state_t;

endpackage : qpcf_pkg

// ===== verification/qpcf_mcu_model.sv
// Controller model that frames serial transfers on select, clock and data lines
`timescale 1ns/1ps
`default_nettype none

module qpcf_mcu_model (
    input wire logic clk,       // System clock, used only for pacing
    input wire logic sdoPin,    // Resolved serial output line
    output logic csN,           // Chip select, active low
    output logic sclk,          // Serial clock, still between frames
    output logic sdi            // Serial data toward the device
);
    // ========================================================
    // Idle levels
    // ========================================================
    initial begin
        csN = 1'h1;
        sclk = 1'h0;
        sdi = 1'h0;
    end

    // One frame of n clocks, 400 ns each; bit n-1 of data goes first
    task automatic frame(input int n, input logic [7:0] data, output logic [7:0] got);
        got = 8'h00;
        @(negedge clk);
        csN = 1'h0;
        repeat (4) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi = data[i];
            repeat (5) @(negedge clk);
            got = {got[6:0], sdoPin};   // Sampled at the end of the low phase
            sclk = 1'h1;
            repeat (3) @(negedge clk);
            sclk = 1'h0;
        end
        repeat (4) @(negedge clk);
        csN = 1'h1;
        sdi = ~sdi;                     // Unselected data line shows no stale value
    endtask : frame
endmodule : qpcf_mcu_model

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the quad predriver control and fault block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct {
        logic [3:0] par;
        int n;
        logic [7:0] data;
        logic [3:0] gate;
        logic [7:0] got;
    } qpcf_row_t;
    logic clk, rst, sclk, csN, sdi, sdo, sdoOe, faultFlagN, sdoHeld;
    logic [3:0] parallelCtrlIn, drainSenseIn, gateDriveOut;
    logic [7:0] got;
    wire logic sdoPin;
    int nMismatch, nCompared, cycles, cyc;
    qpcf_row_t rows [5];

    // ========================================================
    // Design, controller model and three-state line
    // ========================================================
    qpcf_top #(.RETRY_PERIOD_CYCLES(2000)) uut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
        .sdi(sdi), .parallelCtrlIn(parallelCtrlIn), .drainSenseIn(drainSenseIn), .sdo(sdo),
        .sdoOe(sdoOe), .gateDriveOut(gateDriveOut), .faultFlagN(faultFlagN));
    qpcf_mcu_model mcu (.clk(clk), .sdoPin(sdoPin), .csN(csN), .sclk(sclk), .sdi(sdi));
    // Floating output shows the inverse of its last driven value
    always @(posedge clk) if (sdoOe) sdoHeld <= sdo;
    assign sdoPin = sdoOe ? sdo : ~sdoHeld;

    // Clock and hang guard
    initial begin
        clk = 1'h0;
        sdoHeld = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            stopTest();
        end
    end

    // ========================================================
    // Shared tasks
    // ========================================================
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        nCompared++;
        if (act !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, act, exp);
            nMismatch++;
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic doFrame(input int n, input logic [7:0] data);
        mcu.frame(n, data, got);
        idle(8);
        chk({7'h0, sdoOe}, 8'h00);
    endtask : doFrame
    task automatic waitGate(input int ch, input logic lvl, input int lim);
        cyc = 0;
        while (gateDriveOut[ch] !== lvl && cyc < lim) begin
            @(negedge clk);
            cyc++;
        end
    endtask : waitGate
    task automatic stopTest();
        $display("Compared %0d, mismatches %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stopTest

    // ========================================================
    // Main sequence
    // ========================================================
    initial begin
        rst = 1'h1;
        parallelCtrlIn = 4'h0;
        drainSenseIn = 4'h0;
        rows[0] = '{4'h0, 4, 8'h0a, 4'ha, 8'h00};
        rows[1] = '{4'h5, 4, 8'h02, 4'h7, 8'h00};
        rows[2] = '{4'h0, 8, 8'h3c, 4'hc, 8'h03};
        rows[3] = '{4'h1, -1, 8'h00, 4'hd, 8'h00};
        rows[4] = '{4'h0, 4, 8'h00, 4'h0, 8'h00};
        idle(2);
        rst = 1'h0;
        chk({gateDriveOut, sdoOe, faultFlagN, 2'h0}, 8'h04); // Reset levels
        idle(4);
        $display("Test reset done");
        // Table of serial and parallel control cases, no drain fault
        foreach (rows[i]) begin
            parallelCtrlIn = rows[i].par;
            if (rows[i].n >= 0) begin
                doFrame(rows[i].n, rows[i].data);
                chk(got, rows[i].got);
            end
            idle(8);
            chk({4'h0, gateDriveOut}, {4'h0, rows[i].gate});
        end
        $display("Test table done");
        // Shorted load on a serially enabled channel
        drainSenseIn = 4'h1;
        doFrame(4, 8'h01);
        idle(1350);
        chk({3'h0, gateDriveOut, faultFlagN}, 8'h03);
        idle(100);
        chk({3'h0, gateDriveOut, faultFlagN}, 8'h00);
        waitGate(0, 1'h1, 800);
        chk({7'h0, cyc >= 600 && cyc <= 660}, 8'h01);
        waitGate(0, 1'h0, 1500);
        chk({7'h0, cyc >= 1358 && cyc <= 1362}, 8'h01);
        doFrame(4, 8'h01);
        chk(got, 8'h01);
        chk({7'h0, faultFlagN}, 8'h00);
        $display("Test shorted load done");
        // Short frame leaves fault bits in control
        doFrame(1, 8'h00);
        chk({4'h0, gateDriveOut}, 8'h02);
        drainSenseIn = 4'h0;
        doFrame(0, 8'h00);
        chk({3'h0, gateDriveOut, faultFlagN}, 8'h01);
        $display("Test short frame done");
        // Parallel toggle re-enables a channel held off by a short
        drainSenseIn = 4'h4;
        parallelCtrlIn = 4'h4;
        idle(1500);
        chk({3'h0, gateDriveOut, faultFlagN}, 8'h00);
        // Serial bit keeps the request up while the parallel pin toggles
        doFrame(4, 8'h04);
        chk(got, 8'h04);
        parallelCtrlIn = 4'h0;
        idle(6);
        drainSenseIn = 4'h0;
        parallelCtrlIn = 4'h4;
        waitGate(2, 1'h1, 12);
        chk({7'h0, gateDriveOut[2]}, 8'h01);
        idle(1500);
        chk({4'h0, gateDriveOut}, 8'h04);
        doFrame(4, 8'h00);
        chk({got[6:0], faultFlagN}, 8'h01);
        parallelCtrlIn = 4'h0;
        $display("Test parallel recovery done");
        // Reset in mid-run clears control and outputs
        doFrame(4, 8'h0f);
        idle(4);
        chk({4'h0, gateDriveOut}, 8'h0f);
        rst = 1'h1;
        idle(2);
        rst = 1'h0;
        chk({gateDriveOut, sdoOe, faultFlagN, 2'h0}, 8'h04); // Reset levels
        idle(8);
        chk({4'h0, gateDriveOut}, 8'h00);
        $display("Test mid-run reset done");
        stopTest();
    end
endmodule : tb_top

`default_nettype wire
